//--- adcpk_cfg.svh
`ifndef ADCPK_CFG_SVH
`define ADCPK_CFG_SVH
// Summary of operation
// - Dropped-sample flag is read-only, set on a lost sample, cleared by reading it.
// - Width code 0 gives 8-bit samples, lowest four bits dropped; code 2 reserved.
// - Width code 1 gives 16-bit samples, low nibble zero, upper byte first.
// - Width code 3 gives 32-bit words, twenty zero bits below, MSB first.
// - Eight-bit field sets samples per packet before closing and reopening.
// - Packet length zero keeps packet open until a control register access or a sample for another destination.
// - Calibration bit converts the internal 0.8 V reference instead of the input.
// - Global enable bit makes per-input control registers ignore writes.
// - Six trigger pulses after enable calibrate and send no packet data.
// - From the seventh pulse on, each pulse delivers a sample to its endpoint.
// - Reset: 16-bit width, length one, calibration off, disabled, dropped flag one.
// - Each trigger rising edge converts the next enabled input in rotation.
// - Per-input word bits 31:8 give destination node and endpoint.
// - Per-input bit 0 enables the input in the rotation.
// - Raw conversion results are twelve bits before formatting.

////////////////////////////////////////////////////////////////////////////////
`define ADCPK_OFF_GEN    8'h20
`define ADCPK_GEN_EN     0
`define ADCPK_GEN_CAL    1
`define ADCPK_LEN_LO     8
`define ADCPK_LEN_HI     15
`define ADCPK_WID_LO     16
`define ADCPK_WID_HI     17
`define ADCPK_DROP       24
`define ADCPK_IN_EN      0
`define ADCPK_DEST_LO    8
`define ADCPK_DEST_HI    31
`define ADCPK_RST_WID    2'h1
`define ADCPK_RST_LEN    8'h01
`define ADCPK_RST_DROP   1'b1
`define ADCPK_W8         2'h0
`define ADCPK_W32        2'h3
`define ADCPK_NB8        3'h1
`define ADCPK_NB16       3'h2
`define ADCPK_NB32       3'h4
`define ADCPK_CAL_PULSES 3'h6
`define ADCPK_END_TOKEN  8'h01
`endif

//--- adcpk_pkg.sv
package adcpk_pkg;
  typedef enum logic [1:0] {
    ADCPK_IDLE,
    ADCPK_DATA,
    ADCPK_END
  } adcpk_state_t;
endpackage

//--- adcpk_top.sv
`timescale 1ns/100ps
`include "adcpk_cfg.svh"
module adcpk_top #(
  parameter int NUM_IN = 4,
  parameter int DW     = 12
) (
  input  wire logic          sys_clk,
  input  wire logic          arst_n,
  input  wire logic          reg_sel,
  input  wire logic          reg_wr,
  input  wire logic [7:0]    reg_addr,
  input  wire logic [31:0]   reg_wdata,
  output logic      [31:0]   reg_rdata,
  output logic               reg_ack,
  input  wire logic          trig,
  output logic               conv_start,
  output logic [$clog2(NUM_IN)-1:0] conv_chan,
  output logic               conv_cal,
  input  wire logic          conv_done,
  input  wire logic [DW-1:0] conv_data,
  output logic               tx_valid,
  output logic               tx_ctl,
  output logic      [7:0]    tx_data,
  output logic      [23:0]   tx_dest,
  input  wire logic          tx_ready
);
  localparam int IW = $clog2(NUM_IN);
  localparam logic [7:0] IN_SPAN = 8'(NUM_IN * 4);

  ////////////////////////////////////////////////////////////////////////////
  // Register file
  logic [NUM_IN-1:0] in_en, next_in_en;
  logic [23:0]       in_dest [NUM_IN];
  logic [23:0]       next_in_dest [NUM_IN];
  logic              en, next_en, cal, next_cal, drop, next_drop;
  logic [7:0]        len, next_len;
  logic [1:0]        wid, next_wid;
  logic [31:0]       next_rdata;
  logic              next_ack, drop_evt, ctl_access;
  logic [IW-1:0]     ridx;

  always_comb begin
    next_in_en   = in_en;
    next_in_dest = in_dest;
    next_en      = en;
    next_cal     = cal;
    next_len     = len;
    next_wid     = wid;
    next_drop    = drop;
    next_rdata   = 32'h0;
    next_ack     = reg_sel;
    ctl_access   = 1'b0;
    ridx         = reg_addr[IW+1:2];
    if (reg_sel && reg_addr == `ADCPK_OFF_GEN) begin
      ctl_access = 1'b1;
      if (reg_wr) begin
        next_en  = reg_wdata[`ADCPK_GEN_EN];
        next_cal = reg_wdata[`ADCPK_GEN_CAL];
        next_len = reg_wdata[`ADCPK_LEN_HI:`ADCPK_LEN_LO];
        next_wid = reg_wdata[`ADCPK_WID_HI:`ADCPK_WID_LO];
      end else begin
        next_rdata[`ADCPK_DROP]                  = drop;
        next_rdata[`ADCPK_WID_HI:`ADCPK_WID_LO]  = wid;
        next_rdata[`ADCPK_LEN_HI:`ADCPK_LEN_LO]  = len;
        next_rdata[`ADCPK_GEN_CAL]               = cal;
        next_rdata[`ADCPK_GEN_EN]                = en;
        next_drop = 1'b0;
      end
    end else if (reg_sel && reg_addr < IN_SPAN && reg_addr[1:0] == 2'h0) begin
      ctl_access = 1'b1;
      if (reg_wr) begin
        if (!en) begin
          next_in_en[ridx]   = reg_wdata[`ADCPK_IN_EN];
          next_in_dest[ridx] = reg_wdata[`ADCPK_DEST_HI:`ADCPK_DEST_LO];
        end
      end else begin
        next_rdata[`ADCPK_DEST_HI:`ADCPK_DEST_LO] = in_dest[ridx];
        next_rdata[`ADCPK_IN_EN]                  = in_en[ridx];
      end
    end
    if (drop_evt) begin
      next_drop = 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      in_en     <= '0;
      in_dest   <= '{default: 24'h0};
      en        <= 1'b0;
      cal       <= 1'b0;
      len       <= `ADCPK_RST_LEN;
      wid       <= `ADCPK_RST_WID;
      drop      <= `ADCPK_RST_DROP;
      reg_rdata <= 32'h0;
      reg_ack   <= 1'b0;
    end else begin
      in_en     <= next_in_en;
      in_dest   <= next_in_dest;
      en        <= next_en;
      cal       <= next_cal;
      len       <= next_len;
      wid       <= next_wid;
      drop      <= next_drop;
      reg_rdata <= next_rdata;
      reg_ack   <= next_ack;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Trigger and conversion sequencing
  logic          trig_s1, trig_s2, trig_s3;
  logic          busy, next_busy, next_start, discard, next_discard;
  logic [IW-1:0] last, next_last, next_chan;
  logic [2:0]    cal_cnt, next_cal_cnt;
  logic [23:0]   cdest, next_cdest;
  logic [IW:0]   pick;

  function automatic logic [IW:0] adcpk_pick(input logic [NUM_IN-1:0] ens,
                                              input logic [IW-1:0]     from);
    logic [IW:0]   res;
    logic [IW-1:0] k;
    res = '0;
    for (int i = NUM_IN; i >= 1; i--) begin
      k = IW'((int'(from) + i) % NUM_IN);
      if (ens[k]) begin
        res = {1'b1, k};
      end
    end
    return res;
  endfunction

  always_comb begin
    next_busy    = busy;
    next_start   = 1'b0;
    next_discard = discard;
    next_last    = last;
    next_chan    = conv_chan;
    next_cal_cnt = cal_cnt;
    next_cdest   = cdest;
    pick         = adcpk_pick(in_en, last);
    if (conv_done) begin
      next_busy = 1'b0;
    end
    if (!en) begin
      next_cal_cnt = 3'h0;
    end else if (trig_s2 && !trig_s3 && !busy) begin
      if (cal_cnt < `ADCPK_CAL_PULSES) begin
        next_cal_cnt = cal_cnt + 3'h1;
        next_start   = 1'b1;
        next_busy    = 1'b1;
        next_discard = 1'b1;
      end else if (pick[IW]) begin
        next_start   = 1'b1;
        next_busy    = 1'b1;
        next_discard = 1'b0;
        next_chan    = pick[IW-1:0];
        next_last    = pick[IW-1:0];
        next_cdest   = in_dest[pick[IW-1:0]];
      end
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      trig_s1    <= 1'b0;
      trig_s2    <= 1'b0;
      trig_s3    <= 1'b0;
      busy       <= 1'b0;
      conv_start <= 1'b0;
      conv_chan  <= '0;
      conv_cal   <= 1'b0;
      discard    <= 1'b0;
      last       <= IW'(NUM_IN - 1);
      cal_cnt    <= 3'h0;
      cdest      <= 24'h0;
    end else begin
      trig_s1    <= trig;
      trig_s2    <= trig_s1;
      trig_s3    <= trig_s2;
      busy       <= next_busy;
      conv_start <= next_start;
      conv_chan  <= next_chan;
      conv_cal   <= cal;
      discard    <= next_discard;
      last       <= next_last;
      cal_cnt    <= next_cal_cnt;
      cdest      <= next_cdest;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sample holder and packet output
  adcpk_pkg::adcpk_state_t st, next_st;
  logic        hold_full, next_hold_full, pkt_open, next_pkt_open;
  logic        close_req, next_close_req, freed;
  logic        next_tx_valid, next_tx_ctl;
  logic [7:0]  next_tx_data, pkt_cnt, next_pkt_cnt;
  logic [23:0] hold_dest, next_hold_dest, next_tx_dest;
  logic [31:0] hold_sh, next_hold_sh;
  logic [2:0]  hold_n, next_hold_n;

  always_comb begin
    next_st        = st;
    next_hold_full = hold_full;
    next_hold_sh   = hold_sh;
    next_hold_n    = hold_n;
    next_hold_dest = hold_dest;
    next_pkt_open  = pkt_open;
    next_pkt_cnt   = pkt_cnt;
    next_close_req = close_req | (ctl_access & pkt_open);
    next_tx_valid  = tx_valid;
    next_tx_ctl    = tx_ctl;
    next_tx_data   = tx_data;
    next_tx_dest   = tx_dest;
    freed          = 1'b0;
    drop_evt       = 1'b0;
    case (st)
      adcpk_pkg::ADCPK_IDLE: begin
        if (close_req && pkt_open) begin
          next_st       = adcpk_pkg::ADCPK_END;
          next_tx_valid = 1'b1;
          next_tx_ctl   = 1'b1;
          next_tx_data  = `ADCPK_END_TOKEN;
        end else if (hold_full && pkt_open && hold_dest != tx_dest) begin
          next_st       = adcpk_pkg::ADCPK_END;
          next_tx_valid = 1'b1;
          next_tx_ctl   = 1'b1;
          next_tx_data  = `ADCPK_END_TOKEN;
        end else if (hold_full) begin
          next_st        = adcpk_pkg::ADCPK_DATA;
          next_pkt_open  = 1'b1;
          next_tx_valid  = 1'b1;
          next_tx_ctl    = 1'b0;
          next_tx_data   = hold_sh[31:24];
          next_tx_dest   = hold_dest;
        end
      end
      adcpk_pkg::ADCPK_DATA: begin
        if (tx_ready) begin
          next_hold_sh = {hold_sh[23:0], 8'h00};
          next_hold_n  = hold_n - 3'h1;
          next_tx_data = hold_sh[23:16];
          if (hold_n == 3'h1) begin
            freed          = 1'b1;
            next_hold_full = 1'b0;
            next_tx_valid  = 1'b0;
            next_pkt_cnt   = pkt_cnt + 8'h01;
            next_st        = adcpk_pkg::ADCPK_IDLE;
            if (len != 8'h00 && pkt_cnt + 8'h01 == len) begin
              next_st       = adcpk_pkg::ADCPK_END;
              next_tx_valid = 1'b1;
              next_tx_ctl   = 1'b1;
              next_tx_data  = `ADCPK_END_TOKEN;
            end
          end
        end
      end
      adcpk_pkg::ADCPK_END: begin
        if (tx_ready) begin
          next_tx_valid  = 1'b0;
          next_tx_ctl    = 1'b0;
          next_pkt_open  = 1'b0;
          next_pkt_cnt   = 8'h00;
          next_close_req = 1'b0;
          next_st        = adcpk_pkg::ADCPK_IDLE;
        end
      end
      default: next_st = adcpk_pkg::ADCPK_IDLE;
    endcase
    if (conv_done && busy && !discard) begin
      if (hold_full && !freed) begin
        drop_evt = 1'b1;
      end else begin
        next_hold_full = 1'b1;
        next_hold_dest = cdest;
        next_hold_sh   = {conv_data, 20'h0};
        if (wid == `ADCPK_W8) begin
          next_hold_n = `ADCPK_NB8;
        end else if (wid == `ADCPK_W32) begin
          next_hold_n = `ADCPK_NB32;
        end else begin
          next_hold_n = `ADCPK_NB16;
        end
      end
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      st        <= adcpk_pkg::ADCPK_IDLE;
      hold_full <= 1'b0;
      hold_sh   <= 32'h0;
      hold_n    <= 3'h0;
      hold_dest <= 24'h0;
      pkt_open  <= 1'b0;
      pkt_cnt   <= 8'h00;
      close_req <= 1'b0;
      tx_valid  <= 1'b0;
      tx_ctl    <= 1'b0;
      tx_data   <= 8'h00;
      tx_dest   <= 24'h0;
    end else begin
      st        <= next_st;
      hold_full <= next_hold_full;
      hold_sh   <= next_hold_sh;
      hold_n    <= next_hold_n;
      hold_dest <= next_hold_dest;
      pkt_open  <= next_pkt_open;
      pkt_cnt   <= next_pkt_cnt;
      close_req <= next_close_req;
      tx_valid  <= next_tx_valid;
      tx_ctl    <= next_tx_ctl;
      tx_data   <= next_tx_data;
      tx_dest   <= next_tx_dest;
    end
  end
endmodule

//--- adcpk_chk_sva.sv
`timescale 1ns/100ps
module adcpk_chk (
  input wire logic        sys_clk,
  input wire logic        arst_n,
  input wire logic        reg_sel,
  input wire logic        reg_wr,
  input wire logic [7:0]  reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic [31:0] reg_rdata,
  input wire logic        trig,
  input wire logic        conv_start,
  input wire logic        conv_cal,
  input wire logic        conv_done,
  input wire logic        tx_valid,
  input wire logic        tx_ctl,
  input wire logic [7:0]  tx_data,
  input wire logic [23:0] tx_dest,
  input wire logic        tx_ready
);
  logic       en_m;
  logic       fresh;
  logic       busy_m;
  logic [2:0] cal_n;
  wire        rd_g = reg_sel && !reg_wr && reg_addr == 8'h20;
  wire        wr_g = reg_sel && reg_wr && reg_addr == 8'h20;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);

  // Mirror of enable, busy and starts since enable
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      en_m   <= 1'h0;
      fresh  <= 1'h1;
      busy_m <= 1'h0;
      cal_n  <= 3'h0;
    end else begin
      if (reg_sel) fresh <= 1'h0;
      if (wr_g) en_m <= reg_wdata[0];
      busy_m <= conv_start || (busy_m && !conv_done);
      if (wr_g && !reg_wdata[0]) cal_n <= 3'h0;
      else if (conv_start && cal_n != 3'h7) cal_n <= cal_n + 3'h1;
    end
  end
////////////////////////////////////////
  property p_rst;
    rd_g && fresh |=> reg_rdata == 32'h0101_0100;
  endproperty
  a_rst: assert property (p_rst)
    else $error("global reset value");
  property p_clr;
    (rd_g ##2 rd_g) and (!conv_done [*3]) |=> !reg_rdata[24];
  endproperty
  a_clr: assert property (p_clr)
    else $error("drop flag not cleared");
  property p_cal;
    wr_g |-> ##2 conv_cal == $past(reg_wdata[1], 2);
  endproperty
  a_cal: assert property (p_cal)
    else $error("calibration select");
  property p_trig;
    $rose(trig) && en_m && !busy_m |-> ##[1:8] conv_start;
  endproperty
  a_trig: assert property (p_trig)
    else $error("trigger not converted");
  property p_start;
    conv_start |=> !conv_start;
  endproperty
  a_start: assert property (p_start)
    else $error("start not a pulse");
  property p_quiet;
    tx_valid |-> cal_n == 3'h7;
  endproperty
  a_quiet: assert property (p_quiet)
    else $error("data during calibration");
  property p_deliver;
    conv_done && cal_n == 3'h7 && !tx_valid |-> ##[1:8] tx_valid;
  endproperty
  a_deliver: assert property (p_deliver)
    else $error("sample not delivered");
  property p_hold;
    tx_valid && !tx_ready |=>
      tx_valid && $stable(tx_data) && $stable(tx_ctl) && $stable(tx_dest);
  endproperty
  a_hold: assert property (p_hold)
    else $error("offer changed");
  property p_end;
    tx_valid && tx_ctl |-> tx_data == 8'h01;
  endproperty
  a_end: assert property (p_end)
    else $error("bad end token");
  c_end: cover property (tx_valid && tx_ready && tx_ctl);
  c_stall: cover property (tx_valid && !tx_ready ##1 tx_valid);
  c_cal: cover property (conv_start && conv_cal);
endmodule
bind adcpk_top adcpk_chk i_chk (
  .sys_clk, .arst_n, .reg_sel, .reg_wr, .reg_addr, .reg_wdata, .reg_rdata, .trig,
  .conv_start, .conv_cal, .conv_done, .tx_valid, .tx_ctl, .tx_data, .tx_dest, .tx_ready
);

//--- adcpk_sink.sv
`timescale 1ns/100ps
module adcpk_sink (
  input  wire logic        sys_clk,
  input  wire logic        arst_n,
  input  wire logic        tx_valid,
  input  wire logic        tx_ctl,
  input  wire logic [7:0]  tx_data,
  input  wire logic [23:0] tx_dest,
  input  wire logic        stall,
  input  wire logic        slow,
  output logic             tx_ready
);
  logic [8:0]  q[$];
  logic [23:0] dest;
  logic        tgl;
////////////////////////////////////////
  // Accepts every cycle unless stalled, or every other cycle when slow
  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      tx_ready <= 1'h0;
      tgl      <= 1'h0;
    end else begin
      tgl      <= !tgl;
      tx_ready <= !stall && (!slow || tgl);
      if (tx_valid && tx_ready) begin
        q.push_back({tx_ctl, tx_data});
        dest <= tx_dest;
      end
    end
  end
endmodule

//--- tb_adcpk_top.sv
`timescale 1ns/100ps
`define CHK(n, e, a) \
  begin \
    comparisons++; \
    if ((a) !== (e)) begin \
      miscompares++; \
      $display("MISMATCH %s exp %0h got %0h", n, e, a); \
    end \
  end
module tb_adcpk_top;
  logic        sys_clk, arst_n, reg_sel, reg_wr, reg_ack, trig, conv_start, conv_cal;
  logic        conv_done, tx_valid, tx_ctl, tx_ready, stall, slow;
  logic [1:0]  conv_chan, dly;
  logic [7:0]  reg_addr, tx_data;
  logic [11:0] conv_data, cv, smp;
  logic [23:0] tx_dest;
  logic [31:0] reg_wdata, reg_rdata;
  int          miscompares, comparisons;

  adcpk_top i_dut (
    .sys_clk, .arst_n, .reg_sel, .reg_wr, .reg_addr, .reg_wdata, .reg_rdata, .reg_ack,
    .trig, .conv_start, .conv_chan, .conv_cal, .conv_done, .conv_data, .tx_valid,
    .tx_ctl, .tx_data, .tx_dest, .tx_ready
  );
  adcpk_sink i_snk (
    .sys_clk, .arst_n, .tx_valid, .tx_ctl, .tx_data, .tx_dest, .stall, .slow, .tx_ready
  );

  initial begin
    sys_clk = 1'h0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  // Converter: result three cycles after start, garbage otherwise
  always @(posedge sys_clk) begin
    if (!arst_n) begin
      dly       <= 2'h0;
      conv_done <= 1'h0;
      conv_data <= 12'h0;
      cv        <= 12'hA5C;
      smp       <= 12'h0;
    end else begin
      dly       <= {dly[0], conv_start};
      conv_done <= dly[1];
      conv_data <= dly[1] ? cv : ~conv_data;
      if (dly[1]) begin
        smp <= cv;
        cv  <= cv + 12'h111;
      end
    end
  end
////////////////////////////////////////
  task end_of_test();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  task hang();
    miscompares++;
    end_of_test();
  endtask

  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, e);
    int i;
    @(posedge sys_clk);
    reg_sel   <= 1'h1;
    reg_wr    <= w;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_sel <= 1'h0;
    @(negedge sys_clk);
    for (i = 0; i < 4 && reg_ack !== 1'h1; i++) @(negedge sys_clk);
    if (i == 4) hang();
    `CHK("rdata", e, reg_rdata)
  endtask

  task automatic pulse();
    @(posedge sys_clk) trig <= 1'h1;
    repeat (4) @(posedge sys_clk);
    trig <= 1'h0;
    repeat (8) @(posedge sys_clk);
  endtask

  task automatic take(input logic [8:0] e);
    int i;
    logic [8:0] v;
    for (i = 0; i < 80 && i_snk.q.size() == 0; i++) @(negedge sys_clk);
    if (i == 80) hang();
    v = i_snk.q.pop_front();
    `CHK("byte", e, v)
  endtask

  task automatic sample(input logic [1:0] w);
    logic [31:0] v;
    pulse();
    v = {smp, 20'h0};
    take({1'h0, v[31:24]});
    if (w != 2'h0) take({1'h0, v[23:16]});
    if (w == 2'h3) take({1'h0, v[15:8]});
    if (w == 2'h3) take({1'h0, v[7:0]});
  endtask

  initial begin
    arst_n      = 1'h0;
    reg_sel     = 1'h0;
    reg_wr      = 1'h0;
    reg_addr    = 8'h0;
    reg_wdata   = 32'h0;
    trig        = 1'h0;
    stall       = 1'h0;
    slow        = 1'h0;
    miscompares = 0;
    comparisons = 0;
    repeat (16) @(posedge sys_clk);
    arst_n <= 1'h1;
    bus(1'h0, 8'h20, 32'h0, 32'h0101_0100);
    bus(1'h0, 8'h20, 32'h0, 32'h0001_0100);
    bus(1'h0, 8'h10, 32'h0, 32'h0);
    bus(1'h1, 8'h00, 32'h1234_56FF, 32'h0);
    bus(1'h1, 8'h20, 32'h0001_0201, 32'h0);
    bus(1'h1, 8'h00, 32'h0, 32'h0);
    bus(1'h0, 8'h00, 32'h0, 32'h1234_5601);
    $display("test registers done");
    repeat (6) pulse();
    `CHK("early", 0, i_snk.q.size())
    sample(2'h1);
    `CHK("chan", 2'h0, conv_chan)
    sample(2'h1);
    take(9'h101);
    `CHK("dest", 24'h123456, i_snk.dest)
    slow <= 1'h1;
    for (int w = 0; w < 4; w++) begin
      bus(1'h1, 8'h20, {14'h0, w[1:0], 16'h0101}, 32'h0);
      sample(w[1:0]);
      take(9'h101);
    end
    $display("test widths done");
    slow <= 1'h0;
    bus(1'h1, 8'h20, 32'h0001_0001, 32'h0);
    sample(2'h1);
    sample(2'h1);
    repeat (20) @(negedge sys_clk);
    `CHK("open", 0, i_snk.q.size())
    bus(1'h0, 8'h04, 32'h0, 32'h0);
    take(9'h101);
    $display("test open packet done");
    stall <= 1'h1;
    repeat (4) pulse();
    bus(1'h0, 8'h20, 32'h0, 32'h0101_0001);
    stall <= 1'h0;
    repeat (80) @(posedge sys_clk);
    i_snk.q.delete();
    $display("test dropped done");
    bus(1'h1, 8'h20, 32'h0001_0103, 32'h0);
    repeat (2) @(negedge sys_clk);
    `CHK("cal", 1'h1, conv_cal)
    sample(2'h1);
    take(9'h101);
    sample(2'h1);
    take(9'h101);
    $display("test calibration done");
    bus(1'h1, 8'h20, 32'h0001_0100, 32'h0);
    bus(1'h1, 8'h08, 32'hABCD_EF01, 32'h0);
    bus(1'h1, 8'h20, 32'h0001_0101, 32'h0);
    repeat (6) pulse();
    sample(2'h1);
    take(9'h101);
    `CHK("chan", 2'h2, conv_chan)
    `CHK("dest", 24'hABCDEF, i_snk.dest)
    sample(2'h1);
    take(9'h101);
    `CHK("chan", 2'h0, conv_chan)
    `CHK("dest", 24'h123456, i_snk.dest)
    $display("test rotation done");
    end_of_test();
  end
endmodule
